// file: hw/sgl_pkg.sv
// Constants for the serial gain code loader
package sgl_pkg;
	localparam int unsigned SHIFT_W = 6;
	localparam logic [5:0] CODE_MIN = 6'h01;
	localparam logic [5:0] CODE_MAX = 6'h3c;
	localparam logic [5:0] CODE_RESET = 6'h01;
	// Gain in half-dB units: code 1 is -25.5 dB, one dB per code step
	localparam int GAIN_HALF_DB_AT_MIN = -51;
	localparam int GAIN_HALF_DB_PER_CODE = 2;
	localparam int unsigned GAIN_HALF_DB_W = 8;
	// Code 1 in half-dB, two's complement
	localparam logic [7:0] GAIN_HALF_DB_RESET = 8'hcd;
	// Power state, one-hot
	typedef enum logic [2:0] {
		SGL_PWR_SLEEP = 3'h1,
		SGL_PWR_IDLE = 3'h2,
		SGL_PWR_TX = 3'h4
	} sgl_pwr_t;
endpackage : sgl_pkg

// file: hw/sgl_sync.sv
// Two-flop synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module sgl_sync #(
	// Level held in reset: the pin's idle level, so release shows no edge
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = d_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign q_o = sync_q;
endmodule : sgl_sync
`default_nettype wire

// file: hw/sgl_loader.sv
// Serial gain code loader: shift register, gain latch, power control
`timescale 1ns/10ps
`default_nettype none
module sgl_loader (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic serial_clk_i,
	input wire logic serial_gain_in_i,
	input wire logic load_enable_n_i,
	input wire logic transmit_enable_i,
	input wire logic sleep_n_i,
	output logic [5:0] gain_code_o,
	output logic [7:0] gain_half_db_o,
	output logic amp_enable_o,
	output logic powered_o,
	output logic output_hiz_o,
	output logic [2:0] pwr_state_o
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int unsigned SYNC_N = 5;
	// Load enable idles high, all other pins idle low
	localparam logic [SYNC_N-1:0] SYNC_RST = 5'h04;
	logic sclk_s;
	logic sdat_s;
	logic len_n_s;
	logic transmit_enable_s;
	logic sleep_n_s;
	logic [SYNC_N-1:0] pin_raw;
	wire logic [SYNC_N-1:0] pin_sync;

	assign pin_raw = {sleep_n_i, transmit_enable_i, load_enable_n_i, serial_gain_in_i, serial_clk_i};
	assign {sleep_n_s, transmit_enable_s, len_n_s, sdat_s, sclk_s} = pin_sync;

	for (genvar gi = 0; gi < SYNC_N; gi++) begin : g_sync
		sgl_sync #(
			.RST_VAL(SYNC_RST[gi])
		) u_sync (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.d_i(pin_raw[gi]),
			.q_o(pin_sync[gi])
		);
	end

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// saturate above max
	function automatic logic [5:0] sat_code(input logic [5:0] raw);
		if (raw > sgl_pkg::CODE_MAX) begin
			sat_code = sgl_pkg::CODE_MAX;
		end else begin
			sat_code = raw;
		end
	endfunction : sat_code

	function automatic logic [7:0] code_to_half_db(input logic [5:0] code);
		int v;
		v = sgl_pkg::GAIN_HALF_DB_AT_MIN
			+ sgl_pkg::GAIN_HALF_DB_PER_CODE * (int'(code) - int'(sgl_pkg::CODE_MIN));
		code_to_half_db = v[7:0];
	endfunction : code_to_half_db

	// Sleep decode shared by the power and impedance outputs
	function automatic logic is_asleep(input sgl_pkg::sgl_pwr_t st);
		is_asleep = (st == sgl_pkg::SGL_PWR_SLEEP);
	endfunction : is_asleep

	// Target state from the pin levels; sleep wins over transmit
	function automatic sgl_pkg::sgl_pwr_t level_state(input logic awake, input logic tx);
		if (!awake) begin
			level_state = sgl_pkg::SGL_PWR_SLEEP;
		end else if (tx) begin
			level_state = sgl_pkg::SGL_PWR_TX;
		end else begin
			level_state = sgl_pkg::SGL_PWR_IDLE;
		end
	endfunction : level_state

	// ----------------------------------------
	// Shift register and gain latch
	// ----------------------------------------
	logic sclk_prev_q;
	logic sclk_prev_d;
	logic len_prev_q;
	logic len_prev_d;
	logic sclk_rise;
	logic len_rise;
	logic [5:0] shift_q;
	logic [5:0] shift_d;
	logic [5:0] gain_q;
	logic [5:0] gain_d;
	logic [7:0] half_db_q;
	logic [7:0] half_db_d;

	// Edge detectors on the synchronised link pins
	always_comb begin
		sclk_prev_d = sclk_s;
		len_prev_d = len_n_s;
		sclk_rise = sclk_s && !sclk_prev_q;
		len_rise = len_n_s && !len_prev_q;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_prev_q <= 1'b0;
			// Idle high avoids a false apply at release
			len_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_prev_d;
			len_prev_q <= len_prev_d;
		end
	end

	always_comb begin
		shift_d = shift_q;
		gain_d = gain_q;
		// shift on rising edge while enabled
		// shifting blocked while load enable high
		if (!len_n_s && sclk_rise) begin
			// older bits fall off the top
			shift_d = {shift_q[sgl_pkg::SHIFT_W-2:0], sdat_s};
		end
		if (len_rise) begin
			gain_d = sat_code(shift_q);
		end
		half_db_d = code_to_half_db(gain_d);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_q <= '0;
			gain_q <= sgl_pkg::CODE_RESET;
			half_db_q <= sgl_pkg::GAIN_HALF_DB_RESET;
		end else begin
			shift_q <= shift_d;
			gain_q <= gain_d;
			half_db_q <= half_db_d;
		end
	end

	// ----------------------------------------
	// Power state
	// ----------------------------------------
	sgl_pkg::sgl_pwr_t pwr_q;
	sgl_pkg::sgl_pwr_t pwr_d;
	logic amp_q;
	logic amp_d;
	logic powered_q;
	logic powered_d;
	logic hiz_q;
	logic hiz_d;

	always_comb begin
		case (pwr_q)
			// sleep held while the pin is low
			sgl_pkg::SGL_PWR_SLEEP: begin
				pwr_d = level_state(sleep_n_s, transmit_enable_s);
			end
			sgl_pkg::SGL_PWR_IDLE: begin
				pwr_d = level_state(sleep_n_s, transmit_enable_s);
			end
			sgl_pkg::SGL_PWR_TX: begin
				pwr_d = level_state(sleep_n_s, transmit_enable_s);
			end
			default: begin
				pwr_d = sgl_pkg::SGL_PWR_SLEEP;
			end
		endcase
		// Decodes registered with the state so they never glitch
		// idle keeps impedance, only amplifier off
		amp_d = (pwr_d == sgl_pkg::SGL_PWR_TX);
		powered_d = !is_asleep(pwr_d);
		hiz_d = is_asleep(pwr_d);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwr_q <= sgl_pkg::SGL_PWR_SLEEP;
			amp_q <= 1'b0;
			powered_q <= 1'b0;
			hiz_q <= 1'b1;
		end else begin
			pwr_q <= pwr_d;
			amp_q <= amp_d;
			powered_q <= powered_d;
			hiz_q <= hiz_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign gain_code_o = gain_q;
	assign gain_half_db_o = half_db_q;
	assign amp_enable_o = amp_q;
	assign powered_o = powered_q;
	assign output_hiz_o = hiz_q;
	assign pwr_state_o = pwr_q;
endmodule : sgl_loader
`default_nettype wire

// file: verif/sgl_loader_properties.sv
// Checker for the serial gain code loader
`timescale 1ns/10ps
`default_nettype none
module sgl_loader_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_enable_n_i,
	input wire logic transmit_enable_i,
	input wire logic sleep_n_i,
	input wire logic [5:0] gain_code_o,
	input wire logic [7:0] gain_half_db_o,
	input wire logic amp_enable_o,
	input wire logic powered_o,
	input wire logic output_hiz_o,
	input wire logic [2:0] pwr_state_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	half_db_a: assert property (gain_half_db_o == {1'b0, gain_code_o, 1'b0} - 8'h35)
		else $error("gain dB off");
	code_max_a: assert property (gain_code_o <= 6'h3c)
		else $error("code over max");
	sleep_on_a: assert property (!sleep_n_i [*4] |=> pwr_state_o == 3'h1)
		else $error("no sleep");
	tx_on_a: assert property ((sleep_n_i && transmit_enable_i) [*4] |=> amp_enable_o)
		else $error("no transmit");
	tx_off_a: assert property ((sleep_n_i && !transmit_enable_i) [*4] |=> pwr_state_o == 3'h2)
		else $error("no idle");
	gain_hold_a: assert property (load_enable_n_i [*8] |=> $stable(gain_code_o))
		else $error("gain moved");
	state_hot_a: assert property ($onehot(pwr_state_o))
		else $error("state not one-hot");
	state_dec_a: assert property (output_hiz_o == !powered_o && amp_enable_o == pwr_state_o[2])
		else $error("decode off");
endmodule : sgl_loader_chk
bind sgl_loader sgl_loader_chk chk (.*);
`default_nettype wire

// file: verif/sgl_ctl_model.sv
// Controller model driving the serial gain link
`timescale 1ns/10ps
`default_nettype none
module sgl_ctl_model (
	output var logic sclk_o,
	output var logic serial_gain_in_o,
	output var logic len_o
);
	initial begin
		sclk_o = 1'b0;
		serial_gain_in_o = 1'b0;
		len_o = 1'b1;
	end
	// enable low over the word, MSB first
	task automatic send(input logic [7:0] w, input int n);
		len_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_gain_in_o = w[i];
			#16 sclk_o = 1'b1;
			#16 sclk_o = 1'b0;
		end
		// Stale data must not look valid
		serial_gain_in_o = ~serial_gain_in_o;
		#16 len_o = 1'b1;
	endtask : send
	// Clock pulses with enable high must not shift
	task automatic stray(input logic d, input int n);
		for (int i = 0; i < n; i++) begin
			serial_gain_in_o = d;
			#16 sclk_o = 1'b1;
			#16 sclk_o = 1'b0;
		end
	endtask : stray
endmodule : sgl_ctl_model
`default_nettype wire

// file: verif/tb.sv
// Testbench for the serial gain code loader
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_i, rst_i, transmit_enable, slp_n, sclk, sdat, len_n, amp, pwr, hiz;
	logic [5:0] code;
	logic [7:0] hdb;
	logic [2:0] st;
	int bad_count, checks;
	sgl_ctl_model ctl (.sclk_o(sclk), .serial_gain_in_o(sdat), .len_o(len_n));
	sgl_loader uut (.clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sclk), .serial_gain_in_i(sdat),
		.load_enable_n_i(len_n), .transmit_enable_i(transmit_enable), .sleep_n_i(slp_n),
		.gain_code_o(code), .gain_half_db_o(hdb), .amp_enable_o(amp), .powered_o(pwr),
		.output_hiz_o(hiz), .pwr_state_o(st));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic final_report();
		if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task automatic t_load(input logic [7:0] w, input int n, input logic [5:0] e);
		ctl.send(w, n);
		#40;
		chk("code", {2'h0, e}, {2'h0, code});
		chk("db", {1'b0, e, 1'b0} - 8'h35, hdb);
	endtask : t_load
	task automatic t_hold();
		ctl.stray(1'b0, 6);
		t_load(8'h00, 0, 6'h3c);
	endtask : t_hold
	task automatic t_reset();
		@(posedge clk_i) #1;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1 rst_i = 1'b0;
		repeat (8) @(posedge clk_i);
		#1 chk("reset code", 8'h01, {2'h0, code});
		chk("reset db", 8'hcd, hdb);
	endtask : t_reset
	task automatic t_pwr(input logic s, input logic t, input logic [2:0] e);
		@(posedge clk_i) #1;
		slp_n = s;
		transmit_enable = t;
		repeat (6) @(posedge clk_i);
		#1 chk("state", {5'h0, e}, {5'h0, st});
		chk("amp", {7'h0, e == 3'h4}, {7'h0, amp});
		chk("hiz", {7'h0, e == 3'h1}, {7'h0, hiz});
		chk("powered", {7'h0, e != 3'h1}, {7'h0, pwr});
	endtask : t_pwr
	initial begin
		bad_count = 0;
		checks = 0;
		rst_i = 1'b1;
		transmit_enable = 1'b0;
		slp_n = 1'b0;
		repeat (16) @(posedge clk_i);
		#1 rst_i = 1'b0;
		chk("rst", 8'h01, {2'h0, code});
		t_pwr(1'b1, 1'b0, 3'h2);
		chk("rst hold", 8'h01, {2'h0, code});
		chk("rst db", 8'hcd, hdb);
		t_load(8'h2a, 6, 6'h2a);
		t_load(8'h4b, 8, 6'h0b);
		t_load(8'h3d, 6, 6'h3c);
		t_load(8'h3f, 6, 6'h3c);
		t_hold();
		t_load(8'h01, 6, 6'h01);
		t_pwr(1'b1, 1'b1, 3'h4);
		t_pwr(1'b0, 1'b1, 3'h1);
		t_pwr(1'b1, 1'b0, 3'h2);
		t_reset();
		final_report();
	end
	initial begin
		#20000;
		bad_count++;
		final_report();
	end
endmodule : tb
`default_nettype wire
